// file: hdl/sadc_frame_ctrl.sv
`timescale 1ns/1ps
`include "sadc_defines.svh"
// Operation
// - valid init frame makes the next frame shift out marker FF00
// - init may also start on frame sync low with select low; ends on first rise
// - sampling window lasts 20 serial clocks, starting after the 4th falling serial clock edge
// - conversion starts after the 24th falling serial clock edge
// - conversion is 22 internal oscillator clocks, at most 2.94 us
// - frame started during conversion shifts out marker FF00 itself
// - each frame shifts out the result of the previous frame's sample, or FF00 if that frame ended before its 24th falling edge
// - output word is 16 result bits, MSB first
// - output released on 17th rising serial clock edge, else on select rising
// - MSB driven after select falls; next bits after each rising serial clock edge
// - with frame sync, MSB driven after frame sync rises
// - power-down after each conversion; wake on select fall or frame sync rise
module sadc_frame_ctrl (
  // clock and reset
  input  wire logic                 SYS_CLK_I,
  input  wire logic                 SRST_I,
  // serial link pins
  input  wire logic                 CS_N_I,
  input  wire logic                 FRAME_SYNC_IN_I,
  input  wire logic                 SCLK_I,
  output logic                      SDO_O,
  output logic                      SDO_OE_O,
  // converter core
  input  wire sadc_pkg::sadc_word_t RESULT_BITS_I,
  output logic                      SAMPLE_O,
  output logic                      CONV_BUSY_O,
  output logic                      POWER_DOWN_O,
  output logic                      INIT_DONE_O
);
  import sadc_pkg::*;

  localparam int CONV_BOUND = `SADC_CONV_MAX_CYC;

  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic [2:0]  sync3_r;
  logic        cs_n;
  logic        fs;
  logic        cs_fall;
  logic        cs_rise;
  logic        fs_rise;
  logic        fs_fall;
  logic        sclk_fall;
  logic        sclk_rise;
  logic        start_cs;
  logic        start_fs;
  logic        load;
  logic        cut;
  logic        push;
  sadc_word_t  load_word;
  sadc_state_t state_r;
  sadc_state_t state_nxt;
  logic [4:0]  fcnt_r;
  logic [4:0]  fcnt_nxt;
  logic [4:0]  fcnt_inc;
  logic        init_r;
  logic        init_nxt;
  logic        marker_r;
  logic        marker_nxt;
  logic        pd_r;
  logic        pd_nxt;
  logic        samp_r;
  logic        samp_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic [5:0]  div_r;
  logic [5:0]  div_nxt;
  logic [4:0]  tick_r;
  logic [4:0]  tick_nxt;
  sadc_word_t  sh_r;
  sadc_word_t  sh_nxt;
  logic [4:0]  rcnt_r;
  logic [4:0]  rcnt_nxt;
  logic        oe_r;
  logic        oe_nxt;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  sadc_word_t  fifo_out_data;

  // two-stage pin synchronisers plus one history stage for edges
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      sync1_r <= `SADC_PIN_RST;
      sync2_r <= `SADC_PIN_RST;
      sync3_r <= `SADC_PIN_RST;
    end else begin
      sync1_r <= {CS_N_I, FRAME_SYNC_IN_I, SCLK_I};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // pin edges, seen only on the second stage and later
  assign cs_n      = sync2_r[2];
  assign fs        = sync2_r[1];
  assign cs_fall   = !cs_n && sync3_r[2];
  assign cs_rise   = cs_n && !sync3_r[2];
  assign fs_rise   = fs && !sync3_r[1];
  assign fs_fall   = !fs && sync3_r[1];
  assign sclk_fall = !sync2_r[0] && sync3_r[0];
  assign sclk_rise = sync2_r[0] && !sync3_r[0];

  // frame starts; during an init frame a sync rise only ends it
  assign start_cs = cs_fall && fs;
  assign start_fs = fs_rise && !cs_n && !(state_r == ST_ACTIVE && !init_r);
  assign load     = start_cs || start_fs;
  assign fcnt_inc = (fcnt_r == `SADC_EDGE_SAT) ? fcnt_r : fcnt_r + 5'h01;

  // a start during a conversion or a counted frame cuts it; that frame has no result to show
  assign cut       = (state_r == ST_CONV) || (state_r == ST_ACTIVE && init_r);
  // word for the new frame: marker, or the previous frame's result
  assign load_word = (marker_r || cut || !fifo_out_valid) ? `SADC_MARKER_WORD : fifo_out_data;

  // frame, conversion and power state
  always_comb begin
    state_nxt  = state_r;
    fcnt_nxt   = fcnt_r;
    init_nxt   = init_r;
    marker_nxt = marker_r;
    pd_nxt     = pd_r;
    div_nxt    = div_r;
    tick_nxt   = tick_r;
    push       = 1'b0;
    if (cs_fall || fs_rise) begin
      pd_nxt = 1'b0;
    end
    if (load) begin
      fcnt_nxt   = '0;
      marker_nxt = 1'b0;
      state_nxt  = start_cs ? ST_ACTIVE : ST_ARMED;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (!init_r && fs_fall && !cs_n) begin
            state_nxt = ST_ACTIVE;
            fcnt_nxt  = '0;
          end
        end
        ST_ARMED: begin
          if (fs_fall) begin
            state_nxt = ST_ACTIVE;
            fcnt_nxt  = '0;
          end else if (cs_rise) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_ACTIVE: begin
          if (!init_r && (cs_rise || fs_rise)) begin
            state_nxt = ST_IDLE;
            if (fcnt_r >= `SADC_INIT_MIN_EDGES && fcnt_r <= `SADC_INIT_MAX_EDGES) begin
              init_nxt   = 1'b1;
              marker_nxt = 1'b1;
            end
          end else if (init_r && cs_rise) begin
            state_nxt  = ST_IDLE;
            marker_nxt = 1'b1;
          end else if (sclk_fall) begin
            fcnt_nxt = fcnt_inc;
            if (init_r && fcnt_inc == `SADC_CONV_START_EDGE) begin
              state_nxt = ST_CONV;
              div_nxt   = '0;
              tick_nxt  = '0;
            end
          end
        end
        ST_CONV: begin
          if (tick_r == `SADC_CONV_CLKS) begin
            if (fifo_in_ready) begin
              push      = 1'b1;
              state_nxt = ST_IDLE;
              pd_nxt    = 1'b1;
            end
          end else if (div_r == 6'(`SADC_OSC_DIV - 1)) begin
            div_nxt  = '0;
            tick_nxt = tick_r + 5'h01;
          end else begin
            div_nxt = div_r + 6'h01;
          end
        end
      endcase
    end
    samp_nxt = (state_nxt == ST_ACTIVE) && init_nxt && (fcnt_nxt >= `SADC_SAMP_FIRST_EDGE);
    busy_nxt = (state_nxt == ST_CONV);
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      state_r  <= ST_IDLE;
      fcnt_r   <= '0;
      init_r   <= 1'b0;
      marker_r <= 1'b0;
      pd_r     <= 1'b0;
      div_r    <= '0;
      tick_r   <= '0;
      samp_r   <= 1'b0;
      busy_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      fcnt_r   <= fcnt_nxt;
      init_r   <= init_nxt;
      marker_r <= marker_nxt;
      pd_r     <= pd_nxt;
      div_r    <= div_nxt;
      tick_r   <= tick_nxt;
      samp_r   <= samp_nxt;
      busy_r   <= busy_nxt;
    end
  end

  // output shifter, MSB first
  always_comb begin
    sh_nxt   = sh_r;
    rcnt_nxt = rcnt_r;
    oe_nxt   = oe_r;
    if (load) begin
      sh_nxt   = load_word;
      rcnt_nxt = '0;
      oe_nxt   = 1'b1;
    end else if (cs_rise) begin
      oe_nxt = 1'b0;
    end else if (oe_r && sclk_rise) begin
      if (rcnt_r == `SADC_OUT_BITS) begin
        oe_nxt = 1'b0;
      end else begin
        sh_nxt   = {sh_r[14:0], 1'b0};
        rcnt_nxt = rcnt_r + 5'h01;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      sh_r   <= '0;
      rcnt_r <= '0;
      oe_r   <= 1'b0;
    end else begin
      sh_r   <= sh_nxt;
      rcnt_r <= rcnt_nxt;
      oe_r   <= oe_nxt;
    end
  end

  // result buffer between conversion and shifter
  sadc_fifo #(
    .W     (`SADC_WORD_W),
    .DEPTH (`SADC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (SYS_CLK_I),
    .srst_i      (SRST_I),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (RESULT_BITS_I),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (load),
    .out_data_o  (fifo_out_data)
  );

  // outputs straight from flops
  assign SDO_O        = sh_r[15];
  assign SDO_OE_O     = oe_r;
  assign SAMPLE_O     = samp_r;
  assign CONV_BUSY_O  = busy_r;
  assign POWER_DOWN_O = pd_r;
  assign INIT_DONE_O  = init_r;

  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);

  sequence s_init_end_ok;
    state_r == ST_ACTIVE && !init_r && !load && (cs_rise || fs_rise)
      && fcnt_r >= `SADC_INIT_MIN_EDGES && fcnt_r <= `SADC_INIT_MAX_EDGES;
  endsequence

  sequence s_last_edge;
    state_r == ST_ACTIVE && init_r && !load && !cs_rise && sclk_fall
      && fcnt_inc == `SADC_CONV_START_EDGE;
  endsequence

  sequence s_conv_cut;
    state_r == ST_CONV && load;
  endsequence

  init_marker_a: assert property (s_init_end_ok |=> init_r && marker_r ##1 !load [*1])
    else $error("valid init frame did not arm the marker word");

  init_reject_a: assert property (state_r == ST_ACTIVE && !init_r && cs_rise
      && fcnt_r > `SADC_INIT_MAX_EDGES |=> !init_r)
    else $error("over-long init frame was accepted");

  conv_start_a: assert property (s_last_edge |=> busy_r && !samp_r)
    else $error("conversion did not start after the last frame edge");

  samp_window_a: assert property (samp_r |-> state_r == ST_ACTIVE
      && fcnt_r >= `SADC_SAMP_FIRST_EDGE && fcnt_r < `SADC_CONV_START_EDGE)
    else $error("sampling outside its window");

  conv_time_a: assert property ($rose(busy_r) && fifo_in_ready
      |-> busy_r [*8] ##[1:CONV_BOUND] (!busy_r || load))
    else $error("conversion time out of range");

  cut_marker_a: assert property (s_conv_cut |=> sh_r == `SADC_MARKER_WORD && !busy_r)
    else $error("cut-short conversion did not load the marker word");

  done_push_a: assert property (busy_r && state_nxt == ST_IDLE && !load
      |-> push ##1 pd_r)
    else $error("finished conversion not stored or no power-down");

  msb_first_a: assert property (load |=> oe_r && SDO_O == $past(load_word[15]))
    else $error("MSB not presented at frame start");

  shift_a: assert property (oe_r && sclk_rise && !load && !cs_rise
      && rcnt_r < `SADC_OUT_BITS |=> sh_r == {$past(sh_r[14:0]), 1'b0})
    else $error("output word did not shift on a rising clock");

  release_a: assert property ((oe_r && sclk_rise && !load
      && rcnt_r == `SADC_OUT_BITS) or (cs_rise && !load) |=> !SDO_OE_O)
    else $error("output not released");

  wake_a: assert property (pd_r && (cs_fall || fs_rise) |=> !pd_r)
    else $error("power-down not left on a wake edge");

endmodule : sadc_frame_ctrl

// file: hdl/sadc_defines.svh
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

// output words
`define SADC_WORD_W          16
`define SADC_MARKER_WORD     16'hff00

// falling-edge counts within a frame
`define SADC_INIT_MIN_EDGES  5'h01
`define SADC_INIT_MAX_EDGES  5'h08
`define SADC_SAMP_FIRST_EDGE 5'h04
`define SADC_CONV_START_EDGE 5'h18
`define SADC_EDGE_SAT        5'h1f

// rising-edge count after which the output is released
`define SADC_OUT_BITS        5'h10

// conversion timing
`define SADC_CONV_CLKS       5'h16
`define SADC_SYS_CLK_KHZ     250000
`define SADC_OSC_MIN_KHZ     7500
`define SADC_OSC_DIV         (`SADC_SYS_CLK_KHZ / `SADC_OSC_MIN_KHZ)
`define SADC_CONV_MAX_NS     2940
`define SADC_CONV_MAX_CYC    ((`SADC_CONV_MAX_NS * `SADC_SYS_CLK_KHZ) / 1000000)

// result buffer
`define SADC_FIFO_DEPTH      8

// pin reset image {cs_n, frame sync, serial clock}
`define SADC_PIN_RST         3'h6

`endif

// file: hdl/sadc_pkg.sv
package sadc_pkg;

  // frame controller states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ARMED  = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_CONV   = 4'h8
  } sadc_state_t;

  typedef logic [15:0] sadc_word_t;

endpackage : sadc_pkg

// file: hdl/sadc_fifo.sv
`timescale 1ns/1ps

module sadc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] wr_nxt;
  logic [AW-1:0] rd_r;
  logic [AW-1:0] rd_nxt;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          do_wr;
  logic          do_rd;

  // honest flags from the occupancy count
  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rd_r];

  // pointer and count update
  always_comb begin
    do_wr   = in_valid_i && in_ready_o;
    do_rd   = out_valid_o && out_ready_i;
    wr_nxt  = do_wr ? wr_r + AW'(1) : wr_r;
    rd_nxt  = do_rd ? rd_r + AW'(1) : rd_r;
    cnt_nxt = cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage, written by index
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

endmodule : sadc_fifo

// file: sim/sadc_host_model.sv
`timescale 1ns/1ps
module sadc_host_model (
  // clock of the bench
  input  wire logic clk_i,
  // pins seen from the host
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  input  wire logic sample_i,
  output logic      cs_n_o,
  output logic      fs_o,
  output logic      sclk_o
);
  import sadc_pkg::*;
  sadc_word_t  word;    // bits captured in the last frame
  logic [23:0] smask;   // acquisition level after each falling edge
  logic        oe_late; // output enable after the 17th rising edge

  // idle levels from time zero, clock low outside frames
  initial begin
    cs_n_o = 1'b1;
    fs_o   = 1'b1;
    sclk_o = 1'b0;
  end

  // half a serial clock: six system clocks, 24 ns
  task automatic half();
    repeat (6) @(posedge clk_i);
    #1;
  endtask : half

  // n serial clocks, capturing data and acquisition level
  task automatic clocks(input int n);
    word    = 'x;
    smask   = '0;
    oe_late = 1'b1;
    for (int i = 0; i < n; i++) begin
      // bit read late in the low phase, where it has stood longest
      if (i < 16 && sdo_oe_i) word[15-i] = sdo_i;
      sclk_o = 1'b1;
      half();
      if (i == 16) oe_late = sdo_oe_i;
      sclk_o = 1'b0;
      half();
      if (i < 24) smask[i] = sample_i;
    end
  endtask : clocks

  // one select frame of n serial clocks, select raised afterwards
  task automatic frame(input int n);
    cs_n_o = 1'b0;
    half();
    half();
    clocks(n);
    cs_n_o = 1'b1;
    half();
    half();
  endtask : frame

  // select held low: sync pulse of half a clock, then n serial clocks
  task automatic sync_frame(input int n);
    fs_o = 1'b1;
    half();
    fs_o = 1'b0;
    half();
    clocks(n);
    half();
    half();
  endtask : sync_frame

  // enter sync mode with sync leading select, or leave it with select leading sync
  task automatic sync_mode(input logic on);
    if (on) begin
      fs_o = 1'b0;
      half();
      cs_n_o = 1'b0;
      half();
    end else begin
      cs_n_o = 1'b1;
      half();
      fs_o = 1'b1;
      half();
    end
  endtask : sync_mode
endmodule : sadc_host_model

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
  import sadc_pkg::*;
  logic       clk, srst, cs_n, fs, sclk, sdo, sdo_oe;
  logic       samp, busy, pdn, init_done;
  sadc_word_t res;
  int         num_errors, compares;

  // system clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  sadc_frame_ctrl dut (
    .SYS_CLK_I(clk), .SRST_I(srst), .CS_N_I(cs_n), .FRAME_SYNC_IN_I(fs),
    .SCLK_I(sclk), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .RESULT_BITS_I(res),
    .SAMPLE_O(samp), .CONV_BUSY_O(busy), .POWER_DOWN_O(pdn), .INIT_DONE_O(init_done));

  sadc_host_model host (
    .clk_i(clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sample_i(samp),
    .cs_n_o(cs_n), .fs_o(fs), .sclk_o(sclk));

  // compare and count
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // bounded wait for the end of a conversion
  task automatic wait_conv(output int cyc);
    cyc = 0;
    while (busy === 1'b1 && cyc < 1000) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    if (cyc >= 1000) begin
      num_errors++;
      $display("[ERR] %0t conversion never ends", $time);
      test_done();
    end
  endtask : wait_conv

  // outputs quiet after reset
  task automatic t_reset();
    check({sdo_oe, samp, busy, pdn, init_done}, 24'h0);
  endtask : t_reset

  // short init frame, then marker word with full window
  task automatic t_marker();
    int c;
    host.frame(4);
    check(init_done, 1'b1);
    res = 16'ha5c3;
    host.frame(24);
    check(host.word, 16'hff00);
    check(host.smask, 24'h7ffff8);
    check(host.oe_late, 1'b0);
    check(busy, 1'b1);
    wait_conv(c);
    check(24'(c >= 440 && c <= 735), 24'h1);
    check(pdn, 1'b1);
  endtask : t_marker

  // pipelined result, then a frame that cuts the conversion short
  task automatic t_pipe_abort();
    int c;
    res = 16'h3c81;
    host.frame(24);
    check(host.word, 16'ha5c3);
    check(pdn, 1'b0);
    res = 16'h5a96;
    host.frame(24);
    check(host.word, 16'hff00);
    wait_conv(c);
    host.frame(24);
    check(host.word, 16'h5a96);
    wait_conv(c);
  endtask : t_pipe_abort

  // frame cut before the 17th rising edge and the 24th falling edge
  task automatic t_cut();
    int c;
    host.frame(10);
    check(sdo_oe, 1'b0);
    check(busy, 1'b0);
    host.frame(24);
    check(host.word, 16'hff00);
    wait_conv(c);
  endtask : t_cut

  // sync-pin frames: buffered result, a cut conversion, then the next result
  task automatic t_sync();
    int c;
    res = 16'h1e2d;
    host.sync_mode(1'b1);
    host.sync_frame(24);
    check(host.word, 16'h5a96);
    check(busy, 1'b1);
    res = 16'h4b78;
    host.sync_frame(24);
    check(host.word, 16'hff00);
    wait_conv(c);
    check(24'(c >= 440 && c <= 735), 24'h1);
    host.sync_frame(24);
    check(host.word, 16'h4b78);
    check(host.oe_late, 1'b0);
    wait_conv(c);
    host.sync_mode(1'b0);
  endtask : t_sync

  // reset in mid-run, over-long init refused, init opened by sync and ended by select
  task automatic t_reinit();
    int c;
    srst = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    repeat (4) @(posedge clk);
    #1;
    host.frame(9);
    check(init_done, 1'b0);
    host.sync_mode(1'b1);
    host.sync_frame(3);
    host.sync_mode(1'b0);
    check(init_done, 1'b1);
    host.sync_mode(1'b1);
    host.sync_frame(24);
    check(host.word, 16'hff00);
    check(host.smask, 24'h7ffff8);
    wait_conv(c);
    check(pdn, 1'b1);
    host.sync_mode(1'b0);
  endtask : t_reinit

  // main sequence
  initial begin
    srst       = 1'b1;
    res        = '0;
    num_errors = 0;
    compares   = 0;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    repeat (4) @(posedge clk);
    #1;
    t_marker();
    t_pipe_abort();
    t_cut();
    t_sync();
    t_reinit();
    test_done();
  end
endmodule : tb
